//--- design/nand_host_pkg.sv
/*
  Shared constants for the NAND host controller: command codes, address
  cycle layout, page geometry, strobe timing and the operation encoding.
  Assumes a 20 MHz system clock.
*/
package nand_host_pkg;

  // System clock period
  localparam int CLOCK_NS = 50;

  // Least times the host waits, in ns, and in cycles rounded up
  localparam int T_WB_NS = 100;
  localparam int T_WHR_NS = 60;
  localparam int T_WW_NS = 100;
  localparam int WB_CYCLES = (T_WB_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WHR_CYCLES = (T_WHR_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WW_CYCLES = (T_WW_NS + CLOCK_NS - 1) / CLOCK_NS;

  // Page geometry
  localparam int PAGE_BYTES = 4352;
  localparam int MAIN_BYTES = 4096;
  localparam int SPARE_BYTES = 256;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int COL_BITS = 13;
  localparam int PAGE_BITS = 6;
  localparam int BLOCK_BITS = 11;
  localparam int ROW_BITS = PAGE_BITS + BLOCK_BITS;

  // Address cycle indices
  localparam logic [2:0] ADDR_FIRST_COL = 3'h0;
  localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;
  localparam logic [2:0] ADDR_LAST = 3'h4;
  localparam logic [2:0] ADDR_ID = 3'h5;

  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_DATA_LOAD = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_START = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // Status byte fields
  localparam int STATUS_FAIL_BIT = 0;

  // Command sequence steps
  localparam logic [1:0] STEP_FIRST = 2'h0;
  localparam logic [1:0] STEP_SECOND = 2'h1;
  localparam logic [1:0] STEP_STATUS = 2'h2;

  // Strobe phases
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_LATCH = 2'h1;
  localparam logic [1:0] PH_HOLD = 2'h2;

  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_ERASE, OP_STATUS, OP_ID, OP_RESET
  } op_type;

endpackage : nand_host_pkg

//--- design/byte_stream_if.sv
/*
  Valid/ready byte stream between the controller and its write buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface byte_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface : byte_stream_if

//--- design/byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Streams
  byte_stream_if.sink fill,
  byte_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  logic not_full;

  // Ready is registered so the block's own ready port stays a flop
  assign push = fill.valid && not_full;
  assign pop = drain.ready && (count != '0);
  assign fill.ready = not_full;
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      not_full <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      not_full <= (next_count != (AW + 1)'(DEPTH));
    end
  end
endmodule : byte_fifo

//--- design/nand_host.sv
/*
  Host controller for an 8-bit asynchronous NAND flash: turns one user
  operation into command, address and data strobe cycles on the device pins.
  Assumes pin inputs are synchronous to i_clock and an external pull-up on
  the ready/busy line.
*/
// Summary of operation
// - Commands latched on write strobe rise, CLE high
// - Address latched on write strobe rise, ALE high
// - Five address bytes for read and program: column twice, row thrice
// - Strobes high during read busy wait
`timescale 1ns/1ps
module nand_host
  import nand_host_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int LEN_BITS = 13
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // User operation request
  input wire logic i_start,
  input wire op_type i_op,
  input wire logic [COL_BITS-1:0] i_column_addr,
  input wire logic [PAGE_BITS-1:0] i_page_in_block_addr,
  input wire logic [BLOCK_BITS-1:0] i_block_number,
  input wire logic [LEN_BITS-1:0] i_len,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_status,
  output logic o_fail,
  // Program data in
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  // Read data out
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // Device pins
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic o_wp_n,
  input wire logic [7:0] i_byte_port,
  output logic [7:0] o_byte_port,
  output logic o_byte_port_oe,
  input wire logic i_ready_busy_n
);

  initial begin
    if (LEN_BITS < COL_BITS || FIFO_DEPTH < 2) begin
      $error("nand_host: LEN_BITS too small for a page or FIFO too shallow");
    end
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_CMD, ST_ADDR, ST_WDATA, ST_WB, ST_RB, ST_WHR,
    ST_RDATA, ST_DONE
  } state_type;

  state_type state;
  op_type op;
  logic [1:0] step;
  logic [1:0] phase;
  logic [2:0] idx;
  logic [2:0] wcnt;
  logic [COL_BITS-1:0] col;
  logic [ROW_BITS-1:0] row;
  logic [LEN_BITS-1:0] len;
  logic [LEN_BITS-1:0] cnt;
  logic [LEN_BITS-1:0] rd_target;
  logic [7:0] code;

  byte_stream_if #(.WIDTH(8)) wr_in ();
  byte_stream_if #(.WIDTH(8)) wr_out ();

  // Write data buffer; a slow user stalls the data phase instead of
  // breaking the page into partial loads
  assign wr_in.valid = i_wr_valid;
  assign wr_in.data = i_wr_data;
  assign o_wr_ready = wr_in.ready;
  assign wr_out.ready = (state == ST_WDATA) && (phase == PH_SETUP);

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .fill(wr_in),
    .drain(wr_out)
  );

  // Address byte for a given cycle
  function automatic logic [7:0] addr_byte(input logic [2:0] i,
                                           input logic [COL_BITS-1:0] c,
                                           input logic [ROW_BITS-1:0] r);
    case (i)
      3'h0: addr_byte = c[7:0];
      3'h1: addr_byte = {3'h0, c[12:8]};
      3'h2: addr_byte = r[7:0];
      3'h3: addr_byte = r[15:8];
      3'h4: addr_byte = {7'h00, r[16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction : addr_byte

  // Command code for the current operation and step
  always_comb begin
    code = CMD_STATUS;
    case (op)
      OP_READ: code = (step == STEP_FIRST) ? CMD_READ_SETUP : CMD_READ_START;
      OP_PROGRAM: begin
        if (step == STEP_FIRST) begin
          code = CMD_DATA_LOAD;
        end else if (step == STEP_SECOND) begin
          code = CMD_PROGRAM;
        end
      end
      OP_ERASE: begin
        if (step == STEP_FIRST) begin
          code = CMD_ERASE_SETUP;
        end else if (step == STEP_SECOND) begin
          code = CMD_ERASE_START;
        end
      end
      OP_ID: code = CMD_ID;
      OP_RESET: code = CMD_RESET;
      default: code = CMD_STATUS;
    endcase
  end

  // Bytes to read: the page data or identification bytes, else one status
  assign rd_target = ((op == OP_READ || op == OP_ID) && step != STEP_STATUS)
                     ? len : LEN_BITS'(1);

  // Sequencer and device pins
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      op <= OP_STATUS;
      step <= STEP_FIRST;
      phase <= PH_SETUP;
      idx <= ADDR_FIRST_COL;
      wcnt <= 3'h0;
      col <= '0;
      row <= '0;
      len <= '0;
      cnt <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_wp_n <= 1'b0;
      o_byte_port <= 8'h00;
      o_byte_port_oe <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_ce_n <= 1'b1;
          if (i_start) begin
            op <= i_op;
            col <= i_column_addr;
            row <= {i_block_number, i_page_in_block_addr};
            len <= (i_len > LEN_BITS'(PAGE_BYTES)) ? LEN_BITS'(PAGE_BYTES) : i_len;
            step <= STEP_FIRST;
            wcnt <= 3'h0;
            o_busy <= 1'b1;
            o_ce_n <= 1'b0;
            o_wp_n <= (i_op == OP_PROGRAM) || (i_op == OP_ERASE);
            state <= ST_SETUP;
          end
        end
        // Let write protect settle before the first write strobe
        ST_SETUP: begin
          wcnt <= wcnt + 1'b1;
          if (wcnt == 3'(WW_CYCLES - 1)) begin
            phase <= PH_SETUP;
            state <= ST_CMD;
          end
        end
        ST_CMD: begin
          case (phase)
            PH_SETUP: begin
              o_cle <= 1'b1;
              o_byte_port <= code;
              o_byte_port_oe <= 1'b1;
              o_we_n <= 1'b0;
              phase <= PH_LATCH;
            end
            PH_LATCH: begin
              o_we_n <= 1'b1;
              phase <= PH_HOLD;
            end
            default: begin
              o_cle <= 1'b0;
              phase <= PH_SETUP;
              wcnt <= 3'h0;
              cnt <= '0;
              if (step != STEP_FIRST) begin
                state <= (step == STEP_STATUS) ? ST_WHR : ST_WB;
              end else if (op == OP_STATUS) begin
                state <= ST_WHR;
              end else if (op == OP_RESET) begin
                state <= ST_WB;
              end else begin
                idx <= (op == OP_ERASE) ? ADDR_FIRST_ROW :
                       (op == OP_ID) ? ADDR_ID : ADDR_FIRST_COL;
                state <= ST_ADDR;
              end
            end
          endcase
        end
        ST_ADDR: begin
          case (phase)
            PH_SETUP: begin
              o_ale <= 1'b1;
              o_byte_port <= addr_byte(idx, col, row);
              o_we_n <= 1'b0;
              phase <= PH_LATCH;
            end
            PH_LATCH: begin
              o_we_n <= 1'b1;
              phase <= PH_HOLD;
            end
            default: begin
              o_ale <= 1'b0;
              phase <= PH_SETUP;
              idx <= idx + 1'b1;
              wcnt <= 3'h0;
              if (idx == ADDR_LAST || idx == ADDR_ID) begin
                step <= STEP_SECOND;
                if (op == OP_PROGRAM) begin
                  state <= (len == '0) ? ST_CMD : ST_WDATA;
                end else if (op == OP_ID) begin
                  step <= STEP_FIRST;
                  state <= ST_WHR;
                end else begin
                  state <= ST_CMD;
                end
              end
            end
          endcase
        end
        // Page data from the buffer, one write strobe per byte
        ST_WDATA: begin
          if (phase == PH_SETUP) begin
            if (wr_out.valid) begin
              o_byte_port <= wr_out.data;
              o_we_n <= 1'b0;
              phase <= PH_LATCH;
            end
          end else begin
            o_we_n <= 1'b1;
            phase <= PH_SETUP;
            cnt <= cnt + 1'b1;
            if (cnt + 1'b1 == len) begin
              state <= ST_CMD;
            end
          end
        end
        // Busy only shows some time after the last write strobe
        ST_WB: begin
          o_byte_port_oe <= 1'b0;
          wcnt <= wcnt + 1'b1;
          if (wcnt == 3'(WB_CYCLES - 1)) begin
            state <= ST_RB;
          end
        end
        // Both strobes stay high until the device reports ready
        ST_RB: begin
          o_we_n <= 1'b1;
          o_re_n <= 1'b1;
          if (i_ready_busy_n) begin
            wcnt <= 3'h0;
            cnt <= '0;
            if (op == OP_READ) begin
              // A zero length read only loads the page
              state <= (len == '0) ? ST_DONE : ST_RDATA;
            end else if (op == OP_RESET) begin
              state <= ST_DONE;
            end else begin
              step <= STEP_STATUS;
              state <= ST_CMD;
            end
          end
        end
        ST_WHR: begin
          o_byte_port_oe <= 1'b0;
          wcnt <= wcnt + 1'b1;
          if (wcnt == 3'(WHR_CYCLES - 1)) begin
            state <= (rd_target == '0) ? ST_DONE : ST_RDATA;
          end
        end
        // One byte per read strobe cycle
        ST_RDATA: begin
          if (phase == PH_SETUP) begin
            o_re_n <= 1'b0;
            phase <= PH_LATCH;
          end else begin
            o_re_n <= 1'b1;
            phase <= PH_SETUP;
            cnt <= cnt + 1'b1;
            if (cnt + 1'b1 == rd_target) begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          o_done <= 1'b1;
          o_busy <= 1'b0;
          o_ce_n <= 1'b1;
          o_wp_n <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Read data capture, sampled at the end of the low read strobe
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_status <= 8'h00;
      o_fail <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      if (state == ST_RDATA && phase == PH_LATCH) begin
        o_rd_valid <= 1'b1;
        o_rd_data <= i_byte_port;
        if (op == OP_STATUS || step == STEP_STATUS) begin
          o_status <= i_byte_port;
          o_fail <= i_byte_port[STATUS_FAIL_BIT];
        end
      end
    end
  end
endmodule : nand_host

//--- bench/nand_host_monitor.sv
/* Pin and handshake checks for the NAND host.
   Assumes binding to nand_host, seeing its ports only. */
`timescale 1ns/1ps
module nand_host_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // User side
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  // Device pins
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_re_n,
  input wire logic o_wp_n,
  input wire logic [7:0] i_byte_port,
  input wire logic [7:0] o_byte_port,
  input wire logic o_byte_port_oe,
  input wire logic i_ready_busy_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic we_q;
  logic [2:0] n_addr;
  // Write strobe history, kept flat so no sampled function is needed
  always_ff @(posedge i_clock) we_q <= o_we_n;
  // Address bytes since the last command byte
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || (we_q && !o_we_n && o_cle)) n_addr <= 3'h0;
    else if (we_q && !o_we_n && o_ale) n_addr <= n_addr + 3'h1;
  end
  a_cmd_latch_ok: assert property ($fell(o_we_n) && o_cle |-> o_byte_port_oe && !o_ale
    ##1 o_we_n && o_cle && $stable(o_byte_port)) else $error("command strobe malformed");
  a_addr_latch_ok: assert property ($fell(o_we_n) && o_ale |-> o_byte_port_oe && !o_cle
    ##1 o_we_n && o_ale && $stable(o_byte_port)) else $error("address strobe malformed");
  a_addr_five_bytes: assert property ($fell(o_we_n) && o_cle && o_byte_port == 8'h30
    |-> n_addr == 3'h5) else $error("read start without five address bytes");
  a_busy_strobes_high: assert property (!i_ready_busy_n |-> o_we_n && o_re_n)
    else $error("strobe moved while device busy");
  a_read_byte_taken: assert property ($fell(o_re_n) |=> o_re_n && o_rd_valid
    && o_rd_data == $past(i_byte_port)) else $error("read byte not delivered");
  a_wp_lead_time: assert property ($rose(o_wp_n) |-> o_we_n[*2])
    else $error("write protect raised too late");
  a_idle_standby: assert property (!o_busy |-> o_ce_n && o_we_n && o_re_n)
    else $error("pins active while idle");
  a_done_ends_op: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done pulse malformed");
  a_start_taken: assert property (i_start && !o_busy |=> o_busy)
    else $error("start not taken");
  c_program: cover property ($fell(o_we_n) && o_cle && o_byte_port == 8'h10);
  c_erase: cover property ($fell(o_we_n) && o_cle && o_byte_port == 8'hD0);
  c_read: cover property ($fell(o_we_n) && o_cle && o_byte_port == 8'h30);
endmodule : nand_host_monitor

bind nand_host nand_host_monitor nand_host_monitor_i (.i_clock, .i_sys_rst, .i_start,
  .o_busy, .o_done, .o_rd_valid, .o_rd_data, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_re_n,
  .o_wp_n, .i_byte_port, .o_byte_port, .o_byte_port_oe, .i_ready_busy_n);

//--- bench/nand_dev_model.sv
/* Behavioural NAND device for the host bench.
   Assumes the bench resolves the byte bus and pulls ready/busy up. */
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] ID_FIRST = 8'h5A, // Arbitrary value
  parameter logic [7:0] ID_NEXT = 8'h3C // Arbitrary value
) (
  // Host strobes and bus
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_bus,
  // Fault request from the bench
  input wire logic i_fail_next,
  // Device outputs
  output logic [7:0] o_dq,
  output logic o_rb_low
);
  logic [7:0] mem [int]; // Absent bytes read as erased
  logic [7:0] pg [int];
  logic [7:0] ab [5];
  logic [7:0] cmd = 8'h00;
  int na = 0;
  int col = 0;
  int row = 0;
  logic fail = 1'b0;
  initial o_dq = 8'h00;
  initial o_rb_low = 1'b0;

  // Busy window after an array operation
  task automatic start_busy;
    fork
      begin
        #60 o_rb_low = 1'b1;
        #BUSY_NS o_rb_low = 1'b0;
      end
    join_none
  endtask : start_busy

  // Latching on write strobe rise; commands other than status and reset ignored once busy
  always @(posedge i_we_n) begin
    if (i_ce_n) ;
    else if (i_cle) begin
      if (o_rb_low && i_bus != 8'h70 && i_bus != 8'h71 && i_bus != 8'hFF) ;
      else case (i_bus)
        8'h00, 8'h80, 8'h60, 8'h90, 8'h70, 8'h71: begin
          cmd = i_bus;
          na = 0;
          col = 0;
          pg.delete();
        end
        8'h30, 8'h3A: if (cmd == 8'h00) start_busy();
        8'h10: if (cmd == 8'h80 && i_wp_n) begin
          foreach (pg[k]) mem[row * 4352 + k] = pg[k];
          fail = i_fail_next;
          start_busy();
        end
        8'hD0: if (cmd == 8'h60 && i_wp_n) begin
          for (int k = (row / 64) * 278528; k < (row / 64 + 1) * 278528; k++)
            if (mem.exists(k)) mem.delete(k);
          fail = 1'b0;
          start_busy();
        end
        8'hFF: begin
          cmd = 8'h00;
          start_busy();
        end
        default: ;
      endcase
    end else if (i_ale && na < 5) begin
      ab[na] = i_bus;
      na++;
      if (na == 2 && cmd != 8'h60) col = {ab[1][4:0], ab[0]};
      row = (cmd == 8'h60) ? {ab[2][0], ab[1], ab[0]} : {ab[4][0], ab[3], ab[2]};
    end else if (cmd == 8'h80 && col < 4352) begin
      pg[col] = i_bus;
      col++;
    end
  end

  // Each read strobe fall serves the next byte
  always @(negedge i_re_n) begin
    if (!i_ce_n) begin
      if (cmd == 8'h70 || cmd == 8'h71) o_dq = {1'b0, !o_rb_low, 5'h00, fail};
      else if (cmd == 8'h90) o_dq = (col == 0) ? ID_FIRST : ID_NEXT;
      else o_dq = mem.exists(row * 4352 + col) ? mem[row * 4352 + col] : 8'hFF;
      col++;
    end
  end
  // Released bus must not look like the last byte
  always @(posedge i_re_n) #20 o_dq = ~o_dq;
endmodule : nand_dev_model

//--- bench/tb_nand_host.sv
/* Self-checking bench for the NAND host against a device model.
   Assumes the monitor and the device model are compiled first. */
`timescale 1ns/1ps
`define check_eq(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_nand_host import nand_host_pkg::*;;
  localparam logic [7:0] ID_A = 8'h5A; // Arbitrary value
  localparam logic [7:0] ID_B = 8'h3C; // Arbitrary value
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_start = 1'b0;
  op_type i_op = OP_STATUS;
  logic [COL_BITS-1:0] i_column_addr = 13'h0000;
  logic [PAGE_BITS-1:0] i_page_in_block_addr = 6'h00;
  logic [BLOCK_BITS-1:0] i_block_number = 11'h000;
  logic [12:0] i_len = 13'h0000;
  logic i_wr_valid = 1'b0;
  logic [7:0] i_wr_data = 8'h00;
  logic fail_next = 1'b0;
  logic o_busy, o_done, o_fail, o_wr_ready, o_rd_valid, o_ce_n, o_cle, o_ale;
  logic o_we_n, o_re_n, o_wp_n, o_byte_port_oe, rb_low;
  logic [7:0] o_status, o_rd_data, o_byte_port, dev_dq;
  wire logic [7:0] bus = o_byte_port_oe ? o_byte_port : dev_dq;
  wire logic rb_n = !rb_low; // Pull-up on the open-drain line
  logic [7:0] rd_q [$];
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  nand_host nand_host_i (.i_clock, .i_sys_rst, .i_start, .i_op, .i_column_addr,
    .i_page_in_block_addr, .i_block_number, .i_len, .o_busy, .o_done, .o_status, .o_fail,
    .i_wr_valid, .i_wr_data, .o_wr_ready, .o_rd_valid, .o_rd_data, .o_ce_n, .o_cle, .o_ale,
    .o_we_n, .o_re_n, .o_wp_n, .i_byte_port(bus), .o_byte_port, .o_byte_port_oe,
    .i_ready_busy_n(rb_n));
  nand_dev_model #(.ID_FIRST(ID_A), .ID_NEXT(ID_B)) nand_dev_model_i (.i_ce_n(o_ce_n),
    .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n), .i_re_n(o_re_n), .i_wp_n(o_wp_n),
    .i_bus(bus), .i_fail_next(fail_next), .o_dq(dev_dq), .o_rb_low(rb_low));

  always #25 i_clock = ~i_clock;
  // Read stream capture and hang guard
  always @(posedge i_clock) begin
    if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // One user operation, bounded wait for its done pulse
  task automatic run_op(input op_type op, input logic [12:0] col, input logic [5:0] pg,
                        input logic [10:0] blk, input logic [12:0] len);
    rd_q.delete();
    i_start <= 1'b1;
    i_op <= op;
    i_column_addr <= col;
    i_page_in_block_addr <= pg;
    i_block_number <= blk;
    i_len <= len;
    @(posedge i_clock);
    i_start <= 1'b0;
    for (int n = 0; n < 3000 && o_done !== 1'b1; n++) @(posedge i_clock);
    `check_eq(o_done, 1'b1)
  endtask : run_op

  // Valid held high across bytes so it is never set twice in a step
  task automatic fill(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) begin
      i_wr_valid <= 1'b1;
      i_wr_data <= base + 8'(k);
      do @(posedge i_clock); while (o_wr_ready !== 1'b1);
    end
    i_wr_valid <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask : fill

  // Stream of n bytes: lead erased, then len bytes counting from base, then erased
  task automatic read_check(input int n, input int lead, input int len, input logic [7:0] base);
    `check_eq(rd_q.size(), n)
    for (int k = 0; k < n; k++) begin
      if (k >= lead && k < lead + len) `check_eq(rd_q[k], base + 8'(k - lead))
      else `check_eq(rd_q[k], 8'hFF)
    end
  endtask : read_check

  initial begin
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    `check_eq(o_ce_n, 1'b1)
    `check_eq(o_wp_n, 1'b0)
    run_op(OP_STATUS, 13'h0000, 6'h00, 11'h000, 13'h0000);
    `check_eq(o_status, 8'h40)
    fill(16, 8'h10);
    `check_eq(o_wr_ready, 1'b0)
    run_op(OP_PROGRAM, 13'h0005, 6'h03, 11'h009, 13'h0010);
    `check_eq(o_status, 8'h40)
    run_op(OP_READ, 13'h0004, 6'h03, 11'h009, 13'h0012);
    read_check(18, 1, 16, 8'h10);
    run_op(OP_READ, 13'h0005, 6'h02, 11'h009, 13'h0001);
    read_check(1, 1, 0, 8'h00);
    fill(4, 8'hC0);
    fail_next <= 1'b1;
    run_op(OP_PROGRAM, 13'h0000, 6'h00, 11'h008, 13'h0004);
    `check_eq(o_fail, 1'b1)
    fail_next <= 1'b0;
    run_op(OP_ERASE, 13'h0000, 6'h00, 11'h009, 13'h0000);
    `check_eq(o_status, 8'h40)
    run_op(OP_READ, 13'h0005, 6'h03, 11'h009, 13'h0002);
    read_check(2, 2, 0, 8'h00);
    run_op(OP_READ, 13'h0000, 6'h00, 11'h008, 13'h0004);
    read_check(4, 0, 4, 8'hC0);
    run_op(OP_READ, 13'h0000, 6'h00, 11'h008, 13'h0000);
    read_check(0, 0, 0, 8'h00);
    run_op(OP_ID, 13'h0000, 6'h00, 11'h000, 13'h0002);
    `check_eq(rd_q[0], ID_A)
    `check_eq(rd_q[1], ID_B)
    run_op(OP_RESET, 13'h0000, 6'h00, 11'h000, 13'h0000);
    `check_eq(o_busy, 1'b0)
    complete_run();
  end
endmodule : tb_nand_host
